// ---- cpf_defines.vh ----
// constants for the program flow and pointer block
`ifndef CPF_DEFINES_VH
`define CPF_DEFINES_VH
`define CPF_PC_W        15
`define CPF_WORD_W      14
`define CPF_IMPL_AW     12
`define CPF_RESET_VEC   15'h0000
`define CPF_INT_VEC     15'h0004
`define CPF_STACK_DEPTH 16
`define CPF_STACK_AW    4
`define CPF_PTR_W       16
`define CPF_PGM_SEL_BIT 15
`define CPF_DATA_W      8
`define CPF_SHADOW_W    40
`define CPF_GPR_BANK    16'h0050
`define CPF_LIN_BASE    16'h2000
`define CPF_LIN_TOP     16'h29AF
`define CPF_BANK_SIZE   16'h0080
`define CPF_GPR_OFS     16'h0020
`define CPF_NUM_INSTR   49
`define CPF_OP_W        6
`define CPF_MODE_DIR    2'h0
`define CPF_MODE_IND    2'h1
`define CPF_MODE_REL    2'h2
`endif

// ---- cpf_flow.v ----
// program counter, return stack, shadows and indirect pointers of the core
//
// Behaviour
// - program counter is 15 bits, spanning 32K words of 14 bits
// - only 4096 words exist; addresses above 0FFFh wrap into them
// - reset starts at 0000h; interrupt entry loads 0004h
// - return stack is its own memory, 16 entries of 15 bits
// - push when full sets overflow, pop when empty sets underflow; optional reset
// - interrupt entry saves core registers to shadows; return from interrupt restores them
// - two independent 16-bit pointers reach data and program memory
// - indirect read with pointer on program memory takes one extra cycle
// - pointers offer a linear view of general purpose RAM across banks
// - decoder accepts exactly 49 instruction codes
// - operands may be direct, indirect through pointers, or pc relative
// - pointer high bit 7 set reads program memory; low 8 bits returned
// - writes through a pointer on program memory never modify it
`timescale 1ns/1ps
`include "cpf_defines.vh"
module cpf_flow #(
    parameter STACK_DEPTH = `CPF_STACK_DEPTH,
    parameter NUM_INSTR   = `CPF_NUM_INSTR
) (
    input  wire                      core_clk,
    input  wire                      arst_n,
    input  wire                      clk_en,
    input  wire                      step,
    input  wire [`CPF_OP_W-1:0]      op_code,
    input  wire [1:0]                addr_mode,
    input  wire [`CPF_PC_W-1:0]      target,
    input  wire [`CPF_PC_W-1:0]      rel_offset,
    input  wire                      do_jump,
    input  wire                      do_call,
    input  wire                      do_return,
    input  wire                      irq_take,
    input  wire                      do_retfie,
    input  wire                      stack_reset_en,
    input  wire                      clr_ovf,
    input  wire                      clr_unf,
    input  wire [`CPF_SHADOW_W-1:0]  core_regs,
    input  wire                      ptr_sel,
    input  wire                      ptr_load,
    input  wire [`CPF_PTR_W-1:0]     ptr_wdata,
    input  wire                      ind_read,
    input  wire                      ind_write,
    input  wire [`CPF_WORD_W-1:0]    pgm_rdata,
    input  wire [`CPF_DATA_W-1:0]    ram_rdata,
    output reg  [`CPF_PC_W-1:0]      pc_reg,
    output wire [`CPF_IMPL_AW-1:0]   fetch_addr,
    output reg                       stack_overflow_flag,
    output reg                       stack_underflow_flag,
    output reg                       soft_reset,
    output reg  [`CPF_SHADOW_W-1:0]  restore_regs,
    output reg                       restore_valid,
    output reg  [`CPF_PTR_W-1:0]     ptr0_reg,
    output reg  [`CPF_PTR_W-1:0]     ptr1_reg,
    output wire [`CPF_PTR_W-1:0]     mem_addr,
    output wire                      mem_is_pgm,
    output wire                      ram_we,
    output reg  [`CPF_DATA_W-1:0]    ind_rdata,
    output reg                       ind_valid,
    output wire                      stall,
    output wire                      op_legal,
    output wire                      op_direct,
    output wire                      op_indirect,
    output wire                      op_relative
);
    localparam ST_IDLE = 2'b01;
    localparam ST_WAIT = 2'b10;
    // sized zeros keep every reset assignment at its target's width
    localparam [`CPF_STACK_AW:0]   SP_EMPTY    = {(`CPF_STACK_AW+1){1'b0}};
    localparam [`CPF_SHADOW_W-1:0] SHADOW_ZERO = {`CPF_SHADOW_W{1'b0}};
    localparam [`CPF_PTR_W-1:0]    PTR_ZERO    = {`CPF_PTR_W{1'b0}};
    localparam [`CPF_DATA_W-1:0]   DATA_ZERO   = {`CPF_DATA_W{1'b0}};

    reg [`CPF_PC_W-1:0]     stack_mem [0:STACK_DEPTH-1];
    reg [`CPF_STACK_AW:0]   sp_reg;
    reg [`CPF_SHADOW_W-1:0] shadow_reg;
    reg [1:0]               state_reg;
    wire [`CPF_PTR_W-1:0]   ptr_cur;
    wire                    push;
    wire                    pop;
    wire                    over;
    wire                    under;
    wire                    run;
    reg  [`CPF_PC_W-1:0]    pc_next;
    wire [`CPF_PC_W:0]      pc_inc;
    wire [`CPF_PC_W:0]      rel_sum;
    wire [`CPF_PC_W-1:0]    ret_addr;
    wire [`CPF_PC_W-1:0]    jump_addr;

    // linear gpr window maps onto the 80-byte bank slices
    function [`CPF_PTR_W-1:0] cpf_map;
        input [`CPF_PTR_W-1:0] p;
        reg   [`CPF_PTR_W-1:0] lin;
        begin
            lin = p - `CPF_LIN_BASE;
            if (p[`CPF_PGM_SEL_BIT]) begin
                cpf_map = p;
            end else if (p >= `CPF_LIN_BASE && p <= `CPF_LIN_TOP) begin
                cpf_map = (lin / `CPF_GPR_BANK) * `CPF_BANK_SIZE
                          + `CPF_GPR_OFS + (lin % `CPF_GPR_BANK);
            end else begin
                cpf_map = p;
            end
        end
    endfunction

    assign run        = clk_en && step && !stall;
    assign push       = run && (do_call || irq_take);
    assign pop        = run && (do_return || do_retfie);
    assign over       = push && (sp_reg == STACK_DEPTH);
    assign under      = pop && (sp_reg == SP_EMPTY);
    assign fetch_addr = pc_reg[`CPF_IMPL_AW-1:0];
    assign ptr_cur    = ptr_sel ? ptr1_reg : ptr0_reg;
    assign mem_addr   = cpf_map(ptr_cur);
    assign mem_is_pgm = ptr_cur[`CPF_PGM_SEL_BIT];
    // program memory is read-only from the pointer side
    assign ram_we     = clk_en && ind_write && !mem_is_pgm;
    // the extra cycle holds the core while the program word arrives;
    // it starts even without step, so an idle core never gets stale data
    assign stall      = ind_read && mem_is_pgm && (state_reg == ST_IDLE);
    assign op_legal   = (op_code < NUM_INSTR);
    assign op_direct  = (addr_mode == `CPF_MODE_DIR);
    assign op_indirect = (addr_mode == `CPF_MODE_IND);
    assign op_relative = (addr_mode == `CPF_MODE_REL);
    // a full stack holds the counter at depth, whose low bits wrap to the top entry
    assign ret_addr   = stack_mem[sp_reg[`CPF_STACK_AW-1:0] - 1'b1];
    // carries are dropped on purpose: the counter wraps around its 32K space
    assign pc_inc     = {1'b0, pc_reg} + 1'b1;
    assign rel_sum    = {1'b0, pc_reg} + {1'b0, rel_offset};
    assign jump_addr  = op_relative ? rel_sum[`CPF_PC_W-1:0] : target;

    always @* begin
        pc_next = pc_inc[`CPF_PC_W-1:0];
        // irq_take outranks every other flow change
        if (irq_take) begin
            pc_next = `CPF_INT_VEC;
        end else if (do_return || do_retfie) begin
            pc_next = (sp_reg == SP_EMPTY) ? `CPF_RESET_VEC : ret_addr;
        end else if (do_jump || do_call) begin
            pc_next = jump_addr;
        end
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_reg               <= `CPF_RESET_VEC;
            sp_reg               <= SP_EMPTY;
            stack_overflow_flag  <= 1'b0;
            stack_underflow_flag <= 1'b0;
            soft_reset           <= 1'b0;
            shadow_reg           <= SHADOW_ZERO;
            restore_regs         <= SHADOW_ZERO;
            restore_valid        <= 1'b0;
            ptr0_reg             <= PTR_ZERO;
            ptr1_reg             <= PTR_ZERO;
            ind_rdata            <= DATA_ZERO;
            ind_valid            <= 1'b0;
            state_reg            <= ST_IDLE;
        end else if (clk_en) begin
            restore_valid <= 1'b0;
            ind_valid     <= 1'b0;
            // one cycle late; the flags survive it so software can read the cause
            soft_reset    <= stack_reset_en && (over || under);
            // a new event wins over a clear in the same cycle
            if (over) begin
                stack_overflow_flag <= 1'b1;
            end else if (clr_ovf) begin
                stack_overflow_flag <= 1'b0;
            end
            if (under) begin
                stack_underflow_flag <= 1'b1;
            end else if (clr_unf) begin
                stack_underflow_flag <= 1'b0;
            end
            if (soft_reset) begin
                pc_reg <= `CPF_RESET_VEC;
                sp_reg <= SP_EMPTY;
            end else if (run) begin
                pc_reg <= pc_next;
                if (push && !over) begin
                    sp_reg <= sp_reg + 1'b1;
                end else if (pop && !under) begin
                    sp_reg <= sp_reg - 1'b1;
                end
            end
            if (run && irq_take) begin
                shadow_reg <= core_regs;
            end
            if (run && do_retfie) begin
                restore_regs  <= shadow_reg;
                restore_valid <= 1'b1;
            end
            if (ptr_load && !ptr_sel) begin
                ptr0_reg <= ptr_wdata;
            end
            if (ptr_load && ptr_sel) begin
                ptr1_reg <= ptr_wdata;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (stall) begin
                        state_reg <= ST_WAIT;
                    end else if (ind_read) begin
                        ind_rdata <= ram_rdata;
                        ind_valid <= 1'b1;
                    end
                end
                ST_WAIT: begin
                    // the upper bits of the program word are not visible here
                    ind_rdata <= pgm_rdata[`CPF_DATA_W-1:0];
                    ind_valid <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // no reset on the array: an entry means nothing until it is pushed
    always @(posedge core_clk) begin
        if (clk_en && !soft_reset && push && !over) begin
            stack_mem[sp_reg[`CPF_STACK_AW-1:0]] <= pc_inc[`CPF_PC_W-1:0];
        end
    end
endmodule // cpf_flow

// ---- cpf_flow_asserts.sv ----
// assertions for the program flow block
`timescale 1ns/1ps
`include "cpf_defines.vh"
module cpf_flow_asserts #(parameter NUM_INSTR = 49) (
    input wire        core_clk, arst_n, clk_en, step, irq_take, soft_reset,
    input wire        clr_ovf, clr_unf, ptr_sel, ptr_load, mem_is_pgm, ram_we,
    input wire        stack_overflow_flag, stack_underflow_flag, ind_valid, stall, op_legal,
    input wire [5:0]  op_code,
    input wire [14:0] pc_reg,
    input wire [11:0] fetch_addr,
    input wire [15:0] ptr_wdata, ptr0_reg, ptr1_reg
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire take = clk_en && step && !stall;
    // program read: one stalled cycle, then the instruction is taken
    sequence s_wait; stall ##1 (!stall && clk_en && step); endsequence
    property p_fetch; fetch_addr == pc_reg[11:0]; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch address wrong");
    property p_vec; take && irq_take && !soft_reset |=> pc_reg == 15'h0004; endproperty
    a_vec: assert property (p_vec) else $error("interrupt vector wrong");
    property p_srst; soft_reset && clk_en |=> pc_reg == 15'h0000; endproperty
    a_srst: assert property (p_srst) else $error("stack reset missed");
    property p_ovf; stack_overflow_flag && !clr_ovf |=> stack_overflow_flag; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag lost");
    property p_unf; stack_underflow_flag && !clr_unf |=> stack_underflow_flag; endproperty
    a_unf: assert property (p_unf) else $error("underflow flag lost");
    property p_sel; mem_is_pgm == (ptr_sel ? ptr1_reg[15] : ptr0_reg[15]); endproperty
    a_sel: assert property (p_sel) else $error("memory select wrong");
    property p_nowr; mem_is_pgm |-> !ram_we; endproperty
    a_nowr: assert property (p_nowr) else $error("write to program space");
    property p_one; stall && clk_en |=> !stall; endproperty
    a_one: assert property (p_one) else $error("stall too long");
    property p_rd; s_wait |=> ind_valid; endproperty
    a_rd: assert property (p_rd) else $error("program read data late");
    property p_leg; op_legal == (op_code < NUM_INSTR); endproperty
    a_leg: assert property (p_leg) else $error("opcode legality wrong");
    property p_ld; ptr_load && !ptr_sel && clk_en |=> ptr0_reg == $past(ptr_wdata); endproperty
    a_ld: assert property (p_ld) else $error("pointer load wrong");
endmodule // cpf_flow_asserts
bind cpf_flow cpf_flow_asserts #(.NUM_INSTR(NUM_INSTR)) cpf_flow_asserts_inst (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .step(step), .irq_take(irq_take),
    .soft_reset(soft_reset), .clr_ovf(clr_ovf), .clr_unf(clr_unf), .ptr_sel(ptr_sel),
    .ptr_load(ptr_load), .mem_is_pgm(mem_is_pgm), .ram_we(ram_we),
    .stack_overflow_flag(stack_overflow_flag), .stack_underflow_flag(stack_underflow_flag),
    .ind_valid(ind_valid), .stall(stall), .op_legal(op_legal), .op_code(op_code),
    .pc_reg(pc_reg), .fetch_addr(fetch_addr), .ptr_wdata(ptr_wdata), .ptr0_reg(ptr0_reg),
    .ptr1_reg(ptr1_reg)
);

// ---- cpf_flow_tb.sv ----
// self-checking testbench for the program flow block
`timescale 1ns/1ps
module cpf_flow_tb;
    logic core_clk=0, arst_n=0, clk_en=1, step=0, do_jump=0, do_call=0, do_return=0;
    logic irq_take=0, do_retfie=0, stack_reset_en=0, clr_ovf=0, clr_unf=0, ptr_sel=0;
    logic ptr_load=0, ind_read=0, ind_write=0;
    logic [5:0] op_code=0; logic [1:0] addr_mode=0; logic [14:0] target=0, rel_offset=0;
    logic [39:0] core_regs=0; logic [15:0] ptr_wdata=0;
    logic [13:0] pgm_rdata=14'h3ABC; logic [7:0] ram_rdata=8'h5A;
    wire [14:0] pc_reg; wire [11:0] fetch_addr; wire [39:0] restore_regs;
    wire [15:0] ptr0_reg, ptr1_reg, mem_addr; wire [7:0] ind_rdata;
    wire stack_overflow_flag, stack_underflow_flag, soft_reset, restore_valid, mem_is_pgm;
    wire ram_we, ind_valid, stall, op_legal, op_direct, op_indirect, op_relative;
    int total_checks = 0, miscompares = 0, n;
    cpf_flow cpf_flow_inst (
        .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .step(step), .op_code(op_code),
        .addr_mode(addr_mode), .target(target), .rel_offset(rel_offset), .do_jump(do_jump),
        .do_call(do_call), .do_return(do_return), .irq_take(irq_take), .do_retfie(do_retfie),
        .stack_reset_en(stack_reset_en), .clr_ovf(clr_ovf), .clr_unf(clr_unf),
        .core_regs(core_regs), .ptr_sel(ptr_sel), .ptr_load(ptr_load), .ptr_wdata(ptr_wdata),
        .ind_read(ind_read), .ind_write(ind_write), .pgm_rdata(pgm_rdata), .ram_rdata(ram_rdata),
        .pc_reg(pc_reg), .fetch_addr(fetch_addr), .stack_overflow_flag(stack_overflow_flag),
        .stack_underflow_flag(stack_underflow_flag), .soft_reset(soft_reset),
        .restore_regs(restore_regs), .restore_valid(restore_valid), .ptr0_reg(ptr0_reg),
        .ptr1_reg(ptr1_reg), .mem_addr(mem_addr), .mem_is_pgm(mem_is_pgm), .ram_we(ram_we),
        .ind_rdata(ind_rdata), .ind_valid(ind_valid), .stall(stall), .op_legal(op_legal),
        .op_direct(op_direct), .op_indirect(op_indirect), .op_relative(op_relative)
    );
    always #50 core_clk = ~core_clk;
    task chk(input string nm, input logic [39:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task tk; @(negedge core_clk); endtask
    // one instruction: {call, return, retfie, irq, jump}
    task ins(input [4:0] f);
        {do_call, do_return, do_retfie, irq_take, do_jump} = f; step = 1; tk;
        {do_call, do_return, do_retfie, irq_take, do_jump} = 5'h0; step = 0;
    endtask
    task bad; miscompares++; stop_test; endtask
    task t_jump;
        target = 15'h1ABC; ins(5'h01);
        chk("pc_jump", pc_reg, 15'h1ABC);
        chk("fetch_wrap", fetch_addr, 12'hABC);
        addr_mode = 2'h2; rel_offset = 15'h0010; ins(5'h01); addr_mode = 2'h0;
        chk("pc_rel", pc_reg, 15'h1ACC);
        clk_en = 0; ins(5'h01); clk_en = 1;
        chk("pc_frozen", pc_reg, 15'h1ACC);
    endtask
    task t_irq;
        core_regs = 40'hA512345678; ins(5'h02); core_regs = 40'h0;
        chk("pc_irq", pc_reg, 15'h0004);
        ins(5'h04);
        chk("restore_valid", restore_valid, 1'h1);
        chk("restore_regs", restore_regs, 40'hA512345678);
        chk("pc_ret", pc_reg, 15'h1ACD);
    endtask
    task t_stack;
        stack_reset_en = 1;
        for (n = 0; n < 16; n++) ins(5'h10);
        chk("ovf_early", stack_overflow_flag, 1'h0);
        ins(5'h10);
        chk("ovf_set", stack_overflow_flag, 1'h1);
        for (n = 0; n < 4 && soft_reset !== 1'b1; n++) tk;
        if (n == 4) bad;
        tk; tk;
        chk("pc_soft", pc_reg, 15'h0000);
        chk("ovf_sticky", stack_overflow_flag, 1'h1);
        clr_ovf = 1; tk; clr_ovf = 0;
        chk("ovf_clr", stack_overflow_flag, 1'h0);
        stack_reset_en = 0; ins(5'h01); ins(5'h08);
        chk("unf_set", stack_underflow_flag, 1'h1);
        chk("pc_unf", pc_reg, 15'h0000);
        clr_unf = 1; tk; clr_unf = 0;
        chk("unf_clr", stack_underflow_flag, 1'h0);
    endtask
    task t_ptr;
        ptr_sel = 1; ptr_wdata = 16'h8123; ptr_load = 1; tk; ptr_load = 0;
        chk("ptr1", ptr1_reg, 16'h8123);
        ind_read = 1; step = 1; #1;
        chk("stall", stall, 1'h1);
        chk("pgm_sel", mem_is_pgm, 1'h1);
        tk;
        chk("stall_once", stall, 1'h0);
        tk; ind_read = 0; step = 0;
        for (n = 0; n < 3 && ind_valid !== 1'b1; n++) tk;
        if (n == 3) bad;
        chk("pgm_low", ind_rdata, 8'hBC);
        ind_write = 1; step = 1; #1;
        chk("no_pgm_wr", ram_we, 1'h0);
        tk; ptr_sel = 0; ptr_wdata = 16'h2050; ptr_load = 1; tk; ptr_load = 0;
        chk("ptr0", ptr0_reg, 16'h2050);
        chk("lin_addr", mem_addr, 16'h00A0);
        chk("ram_wr", ram_we, 1'h1);
        ind_write = 0; ind_read = 1; tk; ind_read = 0; step = 0;
        chk("ram_valid", ind_valid, 1'h1);
        chk("ram_data", ind_rdata, 8'h5A);
    endtask
    task t_ops;
        for (n = 0; n < 64; n++) begin
            op_code = n[5:0]; addr_mode = n[1:0]; tk;
            chk("op_legal", op_legal, n < 49);
            chk("op_mode", {op_relative, op_indirect, op_direct}, n % 4 < 3 ? 1 << n % 4 : 0);
        end
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        tk; arst_n = 1;
        chk("pc_reset", pc_reg, 15'h0000);
        t_jump; t_irq; t_stack; t_ptr; t_ops;
        stop_test;
    end
endmodule // cpf_flow_tb
